// ==== tcc_top.sv ====
// Timer base with two capture/compare units behind a Wishbone slave
// Contract
// RULE1: Units use the 16-bit counter as base
// RULE2: Capture event copies counter into match pair
// RULE3: Compare match of pair raises an event
// RULE4: Trigger from any unit clears the counter
// RULE5: Trigger clear never sets overflow flag
// RULE6: Compare flag still set in trigger mode
// RULE7: Match pair acts as the timer period
// RULE8: Software picks sync mode and instruction clock
// RULE9: Unsynchronised timer may miss a trigger
// RULE10: Counter write beats a coincident trigger clear
// RULE11: Counter exposed as high and low bytes
// RULE12: Counter wraps all-ones to zero, sets overflow
// RULE13: Count resumes from zero without stall
`include "tcc_defs.svh"
module tcc_top
   import tcc_pkg::*;
#(
   parameter int PRESCALE_DIV = `TCC_PRESCALE_DIV
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_clk_i,
   input wire logic cc1_pin_i,
   input wire logic cc2_pin_i,
   output logic conv_trig_o,
   output logic irq_o
);
   // ************
   // Registers
   // ************
   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic [7:0] tctrl_ff;
   logic [7:0] gctrl_ff;
   logic [7:0] cc1_ctrl_ff;
   logic [7:0] cc2_ctrl_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] nxt_irq_stat;
   logic [2:0] irq_mask_ff;
   logic [31:0] rdata_ff;
   logic ack_ff;
   logic trig_ff;
   logic irq_ff;
   logic [7:0] div_ff;
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic ext_prev_ff;
   tcc_wb_state_t wb_state_ff;

   // ************
   // Bus decode
   // ************
   logic wb_req;
   logic wr_en;
   logic [31:0] rd_mux;
   logic [15:0] match1;
   logic [15:0] match2;
   logic ev1;
   logic ev2;
   logic trig1;
   logic trig2;

   function automatic logic hit_wr(input logic [5:0] off);
      hit_wr = wr_en && (wb_adr_i == off) && wb_sel_i[0];
   endfunction

   // A request is answered once; ack low for the idle cycle after
   assign wb_req = wb_cyc_i && wb_stb_i && (wb_state_ff == TCC_WB_IDLE);
   assign wr_en = wb_req && wb_we_i;

   logic wr_cnt_hi;
   logic wr_cnt_lo;
   logic wr_tctrl;
   logic wr_gctrl;
   logic wr_cc1;
   logic wr_cc2;
   logic wr_m1_hi;
   logic wr_m1_lo;
   logic wr_m2_hi;
   logic wr_m2_lo;
   logic wr_stat;
   logic wr_mask;
   assign wr_cnt_hi = hit_wr(`TCC_OFF_CNT_HI);
   assign wr_cnt_lo = hit_wr(`TCC_OFF_CNT_LO);
   assign wr_tctrl = hit_wr(`TCC_OFF_TCTRL);
   assign wr_gctrl = hit_wr(`TCC_OFF_GCTRL);
   assign wr_cc1 = hit_wr(`TCC_OFF_CC1_CTRL);
   assign wr_cc2 = hit_wr(`TCC_OFF_CC2_CTRL);
   assign wr_m1_hi = hit_wr(`TCC_OFF_MATCH1_HI);
   assign wr_m1_lo = hit_wr(`TCC_OFF_MATCH1_LO);
   assign wr_m2_hi = hit_wr(`TCC_OFF_MATCH2_HI);
   assign wr_m2_lo = hit_wr(`TCC_OFF_MATCH2_LO);
   assign wr_stat = hit_wr(`TCC_OFF_IRQ_STAT);
   assign wr_mask = hit_wr(`TCC_OFF_IRQ_MASK);

   // ************
   // Capture/compare units
   // ************
   tcc_unit u_cc1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(cc1_ctrl_ff[`TCC_CC_MODE_HI:`TCC_CC_MODE_LO]),
      .count_i(count_ff),
      .pin_i(cc1_pin_i),
      .wr_hi_i(wr_m1_hi),
      .wr_lo_i(wr_m1_lo),
      .wdata_i(wb_dat_i[7:0]),
      .match_o(match1),
      .event_o(ev1),
      .trig_o(trig1)
   );

   tcc_unit u_cc2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(cc2_ctrl_ff[`TCC_CC_MODE_HI:`TCC_CC_MODE_LO]),
      .count_i(count_ff),
      .pin_i(cc2_pin_i),
      .wr_hi_i(wr_m2_hi),
      .wr_lo_i(wr_m2_lo),
      .wdata_i(wb_dat_i[7:0]),
      .match_o(match2),
      .event_o(ev2),
      .trig_o(trig2)
   );

   // ************
   // Timer increment source
   // ************
   logic timer_on;
   logic sync_mode;
   logic src_instr;
   logic div_tick;
   logic ext_tick;
   logic inc;
   logic any_trig;
   logic ovf;

   assign timer_on = tctrl_ff[`TCC_TCTRL_ON];
   assign sync_mode = ~tctrl_ff[`TCC_TCTRL_SYNC_N];
   assign src_instr = (tctrl_ff[`TCC_TCTRL_CS_HI:`TCC_TCTRL_CS_LO] == `TCC_CS_INSTR);
   assign div_tick = (div_ff == 8'(PRESCALE_DIV - 1));
   assign ext_tick = ext_sync_ff & ~ext_prev_ff;
   assign inc = timer_on && (src_instr ? div_tick : ext_tick);
   // Trigger honoured only while synchronised; unsynchronised may drop it
   assign any_trig = (trig1 | trig2) && sync_mode; // RULE4 RULE9 RULE8
   // A wrap that a clear or a software load replaces is not an overflow
   assign ovf = inc && (count_ff == `TCC_CNT_ALL_ONES) && !any_trig // RULE5
                && !wr_cnt_hi && !wr_cnt_lo;

   // External clock pin passes two flops before the edge detector
   always_ff @(posedge clk_i) begin
      ext_meta_ff <= ext_clk_i;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
   end

   // Instruction-rate divider, free running
   always_ff @(posedge clk_i) begin
      if (rst_i || div_tick) begin
         div_ff <= `TCC_RST_BYTE;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // Count: a byte write keeps the other byte and drops a coincident clear
   always_comb begin
      nxt_count = count_ff;
      if (wr_cnt_hi || wr_cnt_lo) begin
         nxt_count = count_ff; // RULE10
      end else if (any_trig) begin
         nxt_count = `TCC_RST_WORD; // RULE7 RULE13
      end else if (inc) begin
         nxt_count = count_ff + 16'h0001; // RULE12
      end
      if (wr_cnt_hi) begin
         nxt_count[15:8] = wb_dat_i[7:0]; // RULE10 RULE11
      end
      if (wr_cnt_lo) begin
         nxt_count[7:0] = wb_dat_i[7:0]; // RULE10 RULE11
      end
   end

   // Sticky flags: hardware set beats a write-one clear in the same cycle
   logic [2:0] irq_set;
   assign irq_set = {ev2, ev1, ovf}; // RULE5 RULE6
   assign nxt_irq_stat = (irq_stat_ff & ~(wr_stat ? wb_dat_i[2:0] : 3'h0)) | irq_set;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_ff <= `TCC_RST_WORD;
         irq_stat_ff <= 3'h0;
         trig_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         irq_stat_ff <= nxt_irq_stat;
         trig_ff <= any_trig;
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // ************
   // Control registers
   // ************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tctrl_ff <= `TCC_RST_BYTE;
         gctrl_ff <= `TCC_RST_BYTE;
         cc1_ctrl_ff <= `TCC_RST_BYTE;
         cc2_ctrl_ff <= `TCC_RST_BYTE;
         irq_mask_ff <= 3'h0;
      end else begin
         if (wr_tctrl) tctrl_ff <= wb_dat_i[7:0] & 8'hfd;
         if (wr_gctrl) gctrl_ff <= wb_dat_i[7:0];
         if (wr_cc1) cc1_ctrl_ff <= wb_dat_i[7:0] & 8'h0f;
         if (wr_cc2) cc2_ctrl_ff <= wb_dat_i[7:0] & 8'h0f;
         if (wr_mask) irq_mask_ff <= wb_dat_i[2:0];
      end
   end

   // ************
   // Read mux
   // ************
   assign rd_mux =
      (wb_adr_i == `TCC_OFF_CNT_HI) ? {24'h0, count_ff[15:8]} :
      (wb_adr_i == `TCC_OFF_CNT_LO) ? {24'h0, count_ff[7:0]} :
      (wb_adr_i == `TCC_OFF_TCTRL) ? {24'h0, tctrl_ff} :
      (wb_adr_i == `TCC_OFF_GCTRL) ? {24'h0, gctrl_ff} :
      (wb_adr_i == `TCC_OFF_CC1_CTRL) ? {24'h0, cc1_ctrl_ff} :
      (wb_adr_i == `TCC_OFF_CC2_CTRL) ? {24'h0, cc2_ctrl_ff} :
      (wb_adr_i == `TCC_OFF_MATCH1_HI) ? {24'h0, match1[15:8]} :
      (wb_adr_i == `TCC_OFF_MATCH1_LO) ? {24'h0, match1[7:0]} :
      (wb_adr_i == `TCC_OFF_MATCH2_HI) ? {24'h0, match2[15:8]} :
      (wb_adr_i == `TCC_OFF_MATCH2_LO) ? {24'h0, match2[7:0]} :
      (wb_adr_i == `TCC_OFF_IRQ_STAT) ? {29'h0, irq_stat_ff} :
      (wb_adr_i == `TCC_OFF_IRQ_MASK) ? {29'h0, irq_mask_ff} : 32'h0;

   // One-wait-state answer; unmapped addresses ack with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_state_ff <= TCC_WB_IDLE;
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         case (wb_state_ff)
            TCC_WB_IDLE: begin
               ack_ff <= wb_req;
               rdata_ff <= rd_mux;
               if (wb_req) wb_state_ff <= TCC_WB_ACK;
            end
            TCC_WB_ACK: begin
               ack_ff <= 1'b0;
               wb_state_ff <= TCC_WB_IDLE;
            end
            default: begin
               ack_ff <= 1'b0;
               wb_state_ff <= TCC_WB_IDLE;
            end
         endcase
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign conv_trig_o = trig_ff;
   assign irq_o = irq_ff;
endmodule

// ==== tcc_defs.svh ====
// Register offsets, field positions and reset values of the timer capture/compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// ************
// Offsets
// ************
`define TCC_OFF_CNT_HI 6'h00
`define TCC_OFF_CNT_LO 6'h04
`define TCC_OFF_TCTRL 6'h08
`define TCC_OFF_GCTRL 6'h0c
`define TCC_OFF_CC1_CTRL 6'h10
`define TCC_OFF_CC2_CTRL 6'h14
`define TCC_OFF_MATCH1_HI 6'h18
`define TCC_OFF_MATCH1_LO 6'h1c
`define TCC_OFF_MATCH2_HI 6'h20
`define TCC_OFF_MATCH2_LO 6'h24
`define TCC_OFF_IRQ_STAT 6'h28
`define TCC_OFF_IRQ_MASK 6'h2c
// ************
// Fields
// ************
`define TCC_TCTRL_ON 0
`define TCC_TCTRL_SYNC_N 2
`define TCC_TCTRL_CS_LO 6
`define TCC_TCTRL_CS_HI 7
`define TCC_CC_MODE_LO 0
`define TCC_CC_MODE_HI 3
`define TCC_IRQ_OVF 0
`define TCC_IRQ_CC1 1
`define TCC_IRQ_CC2 2
// ************
// Reset values and mode codes
// ************
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_CS_INSTR 2'h0
`define TCC_CNT_ALL_ONES 16'hffff
`define TCC_PRESCALE_DIV 4
`endif

// ==== tcc_pkg.sv ====
// Types shared by the timer capture/compare block
package tcc_pkg;
   typedef enum logic [3:0] {
      TCC_MODE_OFF = 4'h0,
      TCC_MODE_CAP_FALL = 4'h4,
      TCC_MODE_CAP_RISE = 4'h5,
      TCC_MODE_CMP_FLAG = 4'ha,
      TCC_MODE_CMP_TRIG = 4'hb
   } tcc_mode_t;
   typedef enum logic [1:0] {
      TCC_WB_IDLE,
      TCC_WB_ACK
   } tcc_wb_state_t;
endpackage

// ==== tcc_unit.sv ====
// One capture/compare unit on the shared timer base
`include "tcc_defs.svh"
module tcc_unit
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] mode_i,
   input wire logic [15:0] count_i,
   input wire logic pin_i,
   input wire logic wr_hi_i,
   input wire logic wr_lo_i,
   input wire logic [7:0] wdata_i,
   output logic [15:0] match_o,
   output logic event_o,
   output logic trig_o
);
   logic [15:0] match_ff;
   logic [15:0] nxt_match;
   logic pin_meta_ff;
   logic pin_sync_ff;
   logic pin_prev_ff;
   logic is_cap;
   logic is_cmp;
   logic cap_hit;
   logic cmp_hit;

   // Pin passes two flops before the edge detector looks at it
   always_ff @(posedge clk_i) begin
      pin_meta_ff <= pin_i;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
   end

   // Mode decode and event detection
   assign is_cap = (mode_i == TCC_MODE_CAP_FALL) || (mode_i == TCC_MODE_CAP_RISE);
   assign is_cmp = (mode_i == TCC_MODE_CMP_FLAG) || (mode_i == TCC_MODE_CMP_TRIG);
   assign cap_hit = is_cap && ((mode_i == TCC_MODE_CAP_RISE) ?
                    (pin_sync_ff & ~pin_prev_ff) : (~pin_sync_ff & pin_prev_ff));
   assign cmp_hit = is_cmp && (match_ff == count_i); // RULE3 RULE1
   assign event_o = cap_hit | cmp_hit;
   assign trig_o = cmp_hit && (mode_i == TCC_MODE_CMP_TRIG);
   assign match_o = match_ff;

   // Capture copies the live count; a software write in the same cycle still wins
   always_comb begin
      nxt_match = match_ff;
      if (cap_hit) begin
         nxt_match = count_i; // RULE2
      end
      if (wr_hi_i) begin
         nxt_match[15:8] = wdata_i;
      end
      if (wr_lo_i) begin
         nxt_match[7:0] = wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_ff <= `TCC_RST_WORD;
      end else begin
         match_ff <= nxt_match;
      end
   end
endmodule

// ==== tcc_checker.sv ====
// Port-level assertions for the timer capture/compare block
module tcc_checker #(
   parameter int PRESCALE_DIV = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic conv_trig_o,
   input wire logic irq_o
);
   // Request decode; a held request during its ack cycle is not a new one
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire rd_take = take && !wb_we_i;
   wire mask_clr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h2c && wb_dat_i[7:0] == 8'h00;
   ack_after_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
      take |=> wb_ack_o) else $error("ack missing after request");
   ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_only_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   // Reset itself is the cause here, so it cannot also disable the check
   reset_quiet_a: assert property (@(posedge clk_i)
      rst_i |=> !wb_ack_o && !irq_o && !conv_trig_o) else $error("outputs active after reset");
   upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read data above byte not zero");
   unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_take && wb_adr_i >= 6'h30 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   ctrl_bit_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_take && wb_adr_i == 6'h08 |=> !wb_dat_o[1]) else $error("control bit1 reads one");
   mask_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mask_clr |=> ##1 !irq_o) else $error("irq high with mask cleared");
   trig_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_trig_o |=> !conv_trig_o) else $error("trigger not cleared after match");
endmodule
bind tcc_top tcc_checker #(.PRESCALE_DIV(PRESCALE_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .conv_trig_o(conv_trig_o), .irq_o(irq_o));

// ==== tcc_conv_model.sv ====
// Converter-side model: counts start pulses and measures their spacing
module tcc_conv_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic trig_i,
   output logic [15:0] n_trig_o,
   output logic [15:0] gap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_ff;
   // One conversion start per pulse; spacing equals the timer period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0;
         n_trig_o <= 16'h0;
         gap_o <= 16'h0;
      end else if (trig_i) begin
         cnt_ff <= 16'h1;
         n_trig_o <= n_trig_o + 16'h1;
         gap_o <= cnt_ff;
      end else begin
         cnt_ff <= cnt_ff + 16'h1;
      end
   end
endmodule

// ==== timer_capture_compare_base_test.sv ====
// Self-checking bench for the timer capture/compare block
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH %0t value differs", $time); end end
module timer_capture_compare_base_test;
   timeunit 1ns;
   timeprecision 1ps;
   import tcc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic cc2_pin_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, conv_trig_o, irq_o;
   logic [15:0] n_trig, gap, cval;
   logic [7:0] p, gv;
   logic [31:0] exp_q[$];
   int n_fail = 0;
   int samples_checked = 0;
   int k;
   // Divider of one so periods stay short; expectations use the same figure
   tcc_top #(.PRESCALE_DIV(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(1'b0), .cc1_pin_i(1'b0),
      .cc2_pin_i(cc2_pin_i), .conv_trig_o(conv_trig_o), .irq_o(irq_o));
   tcc_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .trig_i(conv_trig_o),
      .n_trig_o(n_trig), .gap_o(gap));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic summarize();
      $display("Checks %0d, failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One classic cycle; the request holds until ack is sampled high
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) begin
         n_fail++;
         $display("MISMATCH %0t bus timeout", $time);
         summarize();
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      wb(1'b0, a, 8'h00);
   endtask
   // Read data is compared against the oldest note when ack appears
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("MISMATCH %0t unexpected read", $time);
         end else `CHK(wb_dat_o, exp_q.pop_front())
      end
   end
   initial begin
      k = $urandom(25);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(6'h00, 8'h00);
      rd(6'h04, 8'h00);
      rd(6'h30, 8'h00);
      gv = 8'($urandom);
      wb(1'b1, 6'h0c, gv);
      rd(6'h0c, gv);
      // Capture of a stopped count on a rising pin
      cval = 16'($urandom);
      wb(1'b1, 6'h00, cval[15:8]);
      wb(1'b1, 6'h04, cval[7:0]);
      wb(1'b1, 6'h14, 8'h05);
      cc2_pin_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(6'h20, cval[15:8]);
      rd(6'h24, cval[7:0]);
      wb(1'b1, 6'h14, 8'h00);
      wb(1'b1, 6'h28, 8'h07);
      // Wrap from all ones raises the overflow flag
      wb(1'b1, 6'h2c, 8'h01);
      wb(1'b1, 6'h00, 8'hff);
      wb(1'b1, 6'h04, 8'hf0);
      wb(1'b1, 6'h08, 8'h01);
      repeat (30) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      rd(6'h28, 8'h01);
      wb(1'b1, 6'h28, 8'h01);
      rd(6'h28, 8'h00);
      `CHK(irq_o, 1'b0)
      // Compare with trigger: the match pair sets the period
      wb(1'b1, 6'h08, 8'h00);
      p = 8'd8 + 8'($urandom % 24);
      wb(1'b1, 6'h00, 8'h00);
      wb(1'b1, 6'h04, 8'h00);
      wb(1'b1, 6'h18, 8'h00);
      wb(1'b1, 6'h1c, p);
      wb(1'b1, 6'h2c, 8'h02);
      wb(1'b1, 6'h10, 8'h0b);
      wb(1'b1, 6'h08, 8'h01);
      k = 0;
      while (n_trig < 16'd3 && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 2000) begin
         n_fail++;
         $display("MISMATCH %0t trigger timeout", $time);
         summarize();
      end
      `CHK(gap, {8'h0, p} + 16'd1)
      `CHK(irq_o, 1'b1)
      rd(6'h28, 8'h02);
      rd(6'h08, 8'h01);
      wb(1'b1, 6'h2c, 8'h00);
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      summarize();
   end
endmodule
